// >>> bench/sfrc_core_asserts.sv
// port checks of the safety output and restart control block
// assumes: bound into sfrc_core, one clock, sync active-low reset
`timescale 1ns/1ns
module sfrc_chk #(
  parameter int unsigned NBEAMS     = 16,
  parameter int unsigned FB_WIN_CYC = 75000000
) (
  // clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // bus handshakes
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic [1:0]        bresp,
  input wire logic              arready,
  input wire logic              rvalid,
  input wire logic              rready,
  input wire logic [31:0]       rdata,
  // field and outputs
  input wire logic              scan_strobe,
  input wire logic [NBEAMS-1:0] beam_seen,
  input wire logic              safety_switching_output,
  input wire logic              fault_out,
  input wire logic              irq
);
  logic [31:0] since_ff;
  logic        out_q_ff;
  // ****************************************************************
  // age of the last output switch, saturating
  // ****************************************************************
  always_ff @(posedge aclk) begin
    out_q_ff <= safety_switching_output;
    if (!aresetn || out_q_ff != safety_switching_output)
      since_ff <= 32'h0000_0000;
    else if (since_ff != 32'hffff_ffff)
      since_ff <= since_ff + 32'h0000_0001;
  end
  default clocking dcb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_wr_block: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_rd_block: assert property (arready == !rvalid)
    else $error("read ready wrong");
  a_break_off: assert property (
    scan_strobe && !(&beam_seen) |=> !safety_switching_output)
    else $error("output on after field break");
  a_fault_off: assert property (
    fault_out |-> !safety_switching_output)
    else $error("output on in fault");
  a_fault_hold: assert property (
    fault_out && !awvalid && !wvalid && !$past(awvalid) && !$past(wvalid)
    |=> fault_out) else $error("fault left without write");
  a_fb_window: assert property (
    $rose(fault_out) |-> since_ff >= FB_WIN_CYC - 4)
    else $error("feedback fault before window end");
  a_reset_off: assert property (disable iff (1'b0)
    !aresetn |=> !safety_switching_output && !fault_out && !irq
    && !bvalid && !rvalid) else $error("outputs not idle after reset");
endmodule : sfrc_chk

bind sfrc_core sfrc_chk #(.NBEAMS(NBEAMS), .FB_WIN_CYC(FB_WIN_CYC))
  u_sfrc_chk (.*);

// >>> bench/sfrc_partner.sv
// far side model: external contactors and acknowledgment key
// assumes: same clock as the device; not reset by the device reset
`timescale 1ns/1ns
module sfrc_partner #(
  parameter int DLY = 3
) (
  // clock
  input wire logic aclk,
  // from the device and the bench
  input wire logic safety_switching_output,
  input wire logic stuck,
  // to the device
  output logic     feedback_pin,
  output logic     restart_pin
);
  logic [DLY-1:0] hist_ff = '1;
  initial begin
    feedback_pin = 1'b1;
    restart_pin = 1'b0;
  end
  // nc contacts follow the coil late; stuck models welded contacts
  always @(posedge aclk) begin
    hist_ff <= {hist_ff[DLY-2:0], ~safety_switching_output};
    if (!stuck)
      feedback_pin <= hist_ff[DLY-1];
  end
  // key press: low-high-low, held n cycles
  task automatic press(input int n);
    @(posedge aclk);
    restart_pin <= 1'b1;
    repeat (n) @(posedge aclk);
    restart_pin <= 1'b0;
  endtask : press
endmodule : sfrc_partner

// >>> bench/testbench.sv
// self-checking bench of the safety output and restart control block
// assumes: hw/ on the include path; short ack and window counts
`timescale 1ns/1ns
`include "sfrc_consts.svh"
module testbench;
  localparam int NB = 16;
  logic          aclk = 1'b0;
  logic          aresetn = 1'b0;
  logic          awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic          rready = 0, scan_strobe = 0, stuck = 0;
  logic [7:0]    awaddr = 0, araddr = 0;
  logic [31:0]   wdata = 0, rdata;
  logic [3:0]    wstrb = 0;
  logic [NB-1:0] beam_seen = 0, beam_coded = 0, s, cd, a;
  logic          awready, wready, bvalid, arready, rvalid, ssw_out;
  logic          fault_out, irq, fb_pin, rst_pin;
  logic [1:0]    bresp, rresp;
  logic [31:0]   c;
  int            err_total = 0, comparisons = 0, cyc = 0, seed = 95;
  int            pl[3] = '{10, 260, 25};
  always #2 aclk = ~aclk;
  sfrc_core #(.NBEAMS(NB), .ACK_MIN_CYC(20), .ACK_MAX_CYC(200),
    .FB_WIN_CYC(50)) u_sfrc_core (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .scan_strobe(scan_strobe), .beam_seen(beam_seen),
    .beam_coded(beam_coded), .restart_pin(rst_pin),
    .feedback_pin(fb_pin), .safety_switching_output(ssw_out),
    .fault_out(fault_out), .irq(irq));
  sfrc_partner u_sfrc_partner (.aclk(aclk),
    .safety_switching_output(ssw_out), .stuck(stuck),
    .feedback_pin(fb_pin), .restart_pin(rst_pin));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // beams that count: seen, and coded where coding is on
  function automatic logic [NB-1:0] f_acc(input logic [NB-1:0] sn, cdd,
                                          input logic cod);
    return sn & (~{NB{cod}} | cdd);
  endfunction : f_acc
  task automatic axw(input logic [7:0] ad, input logic [31:0] d,
                     input logic [3:0] m);
    logic ta, tw;
    ta = 0;
    tw = 0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= ad;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= m;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && awready) begin
        ta = 1;
        awvalid <= 1'b0;
      end
      if (!tw && wready) begin
        tw = 1;
        wvalid <= 1'b0;
      end
    end
    repeat (2) @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", bresp, 0);
  endtask : axw
  task automatic axr(input logic [7:0] ad, input logic [31:0] m, e,
                     input logic [1:0] re);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= ad;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    chk("rdata", rdata & m, e);
    chk("rresp", rresp, re);
  endtask : axr
  // one scan; returns once the scan edge has landed
  task automatic st(input logic [NB-1:0] sn, cdd);
    @(posedge aclk);
    scan_strobe <= 1'b1;
    beam_seen <= sn;
    beam_coded <= cdd;
    @(posedge aclk);
    scan_strobe <= 1'b0;
    @(posedge aclk);
  endtask : st
  task final_report;
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  // hang guard, far above the thousand or so cycles needed
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      final_report;
    end
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`SFRC_ADDR_CTRL, '1, 32'h0000_0007, 0);
    axr(`SFRC_ADDR_INT_MSK, '1, 32'h0000_0000, 0);
    axr(`SFRC_ADDR_FB_WIN, '1, 32'h0000_0032, 0);
    axr(8'h14, 32'h0000_0000, 32'h0000_0000, `SFRC_RESP_SLVERR);
    st('1, '1);
    chk("start", ssw_out, 0);
    // short, long, then valid key press
    for (int i = 0; i < 3; i++) begin
      u_sfrc_partner.press(pl[i]);
      repeat (8) @(posedge aclk);
      chk("ack", ssw_out, i == 2);
    end
    st('1 ^ 16'h0100, '1);
    chk("brk", ssw_out, 0);
    st('1, '1);
    repeat (20) @(posedge aclk);
    chk("lock", ssw_out, 0);
    u_sfrc_partner.press(190);
    repeat (8) @(posedge aclk);
    chk("ack", ssw_out, 1);
    st('1, '1 ^ 16'h0020);
    chk("code", ssw_out, 0);
    // random fields, lockout off, coding chosen per scan
    for (int i = 0; i < 16; i++) begin
      c = $random(seed);
      s = NB'($random(seed));
      cd = NB'($random(seed));
      if (c[1]) s = '1;
      if (c[2]) cd = '1;
      axw(`SFRC_ADDR_CTRL, {29'h0, c[0], 2'b10}, 4'h1);
      st(s, cd);
      a = f_acc(s, cd, c[0]);
      chk("auto", ssw_out, &a);
      axr(`SFRC_ADDR_STATUS, 32'h10, {a[0] | a[NB-1], 4'h0}, 0);
    end
    // interrupt: clear, mask in, raise, clear again
    axw(`SFRC_ADDR_INT_ST, 32'h0000_000f, 4'h1);
    axw(`SFRC_ADDR_INT_MSK, 32'h0000_0001, 4'hf);
    st('1, '1);
    chk("irq", irq, 0);
    st('0, '1);
    st('1, '1);
    chk("irq", irq, 1);
    axw(`SFRC_ADDR_INT_ST, 32'h0000_0001, 4'h1);
    repeat (2) @(posedge aclk);
    chk("irq", irq, 0);
    // welded contactors: fault only after the window
    stuck <= 1'b1;
    st('0, '1);
    repeat (40) @(posedge aclk);
    chk("fault", fault_out, 0);
    repeat (20) @(posedge aclk);
    chk("fault", fault_out, 1);
    axr(`SFRC_ADDR_STATUS, 32'h4, 32'h4, 0);
    axr(`SFRC_ADDR_INT_ST, 32'h8, 32'h8, 0);
    stuck <= 1'b0;
    st('1, '1);
    chk("safe", ssw_out, 0);
    axw(`SFRC_ADDR_CTRL, 32'h0000_0102, 4'h3);
    chk("fclr", fault_out, 0);
    st('1, '1);
    chk("run", ssw_out, 1);
    // power loss mid-run comes back locked
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    st('1, '1);
    chk("repow", ssw_out, 0);
    final_report;
  end
endmodule : testbench

// >>> hw/sfrc_consts.svh
// constants of the safety output and restart control block
// assumes: included by bare name from the modules and the testbench
`ifndef SFRC_CONSTS_SVH
`define SFRC_CONSTS_SVH

// ****************************************************************
// timing
// ****************************************************************
`define SFRC_CLK_KHZ      250000
`define SFRC_ACK_MIN_MS   100
`define SFRC_ACK_MAX_MS   4000
`define SFRC_FB_WIN_MS    300

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define SFRC_ADDR_CTRL    8'h00
`define SFRC_ADDR_STATUS  8'h04
`define SFRC_ADDR_INT_ST  8'h08
`define SFRC_ADDR_INT_MSK 8'h0C
`define SFRC_ADDR_FB_WIN  8'h10

// ****************************************************************
// fields
// ****************************************************************
`define SFRC_CTRL_LOCK_EN 0
`define SFRC_CTRL_FB_EN   1
`define SFRC_CTRL_CODE_EN 2
`define SFRC_CTRL_ERR_CLR 8
`define SFRC_CTRL_RST     3'h7
`define SFRC_INT_BREAK    0
`define SFRC_INT_ACK_OK   1
`define SFRC_INT_ACK_BAD  2
`define SFRC_INT_FB_FAULT 3
`define SFRC_INT_RST      4'h0
`define SFRC_RESP_OKAY    2'h0
`define SFRC_RESP_SLVERR  2'h2

`endif

// >>> hw/sfrc_core.sv
// safety output and restart control with axi4-lite registers
// assumes: beam inputs come from the optical front end on aclk;
// restart_pin and feedback_pin are asynchronous pins
//
// Contract
// [RQ1] in automatic restart the outputs go off once the field breaks.
// [RQ2] in automatic restart the outputs come back on when it clears.
// [RQ3] with restart lockout off the block runs in automatic restart.
// [RQ4] with lockout on the outputs stay off after a break, field clear.
// [RQ5] the locked condition holds over power loss, outputs off at start.
// [RQ6] under lockout only a valid acknowledgment re-enables outputs.
// [RQ7] a valid ack is a low-high-low pulse with high time 0.1 s to 4 s.
// [RQ8] feedback must reach its state within the window after each switch.
// [RQ9] a late feedback forces safe state: outputs off, error shown.
// [RQ10] with coding on only beams with the own code count as received.
// [RQ11] first or last beam alone is enough to lock code and timing.
// [RQ12] emitter and receiver carry the same single coding on/off choice.
// [RQ13] restart and feedback are synchronised and timed by counters.
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "sfrc_consts.svh"

module sfrc_core import sfrc_pkg::*; #(
  parameter int unsigned NBEAMS      = 16,
  parameter int unsigned ACK_MIN_CYC = `SFRC_ACK_MIN_MS * `SFRC_CLK_KHZ,
  parameter int unsigned ACK_MAX_CYC = `SFRC_ACK_MAX_MS * `SFRC_CLK_KHZ,
  parameter int unsigned FB_WIN_CYC  = `SFRC_FB_WIN_MS * `SFRC_CLK_KHZ
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [7:0]        awaddr,
  // axi4-lite write data
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  // axi4-lite write response
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  // axi4-lite read address
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [7:0]        araddr,
  // axi4-lite read data
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  // optical front end, one scan per strobe
  input  wire logic              scan_strobe,
  input  wire logic [NBEAMS-1:0] beam_seen,
  input  wire logic [NBEAMS-1:0] beam_coded,
  // field pins
  input  wire logic              restart_pin,
  input  wire logic              feedback_pin,
  // outputs
  output logic                   safety_switching_output,
  output logic                   fault_out,
  output logic                   irq
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  sfrc_state_t       state_ff;
  sfrc_state_t       nxt_state;
  logic              out_ff;
  logic              nxt_out;
  logic [2:0]        ctrl_ff;
  logic [3:0]        int_st_ff;
  logic [3:0]        int_msk_ff;
  logic [31:0]       fb_win_ff;
  logic              irq_ff;
  logic              field_clear_ff;
  logic              sync_lock_ff;
  logic              fb_busy_ff;
  logic              fb_expect_ff;
  logic [31:0]       fb_cnt_ff;
  logic              aw_held_ff;
  logic              w_held_ff;
  logic [7:0]        awaddr_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;
  logic [NBEAMS-1:0] beam_ok;
  logic              scan_clear;
  logic              scan_sync;
  logic              field_now;
  logic              lock_en;
  logic              fb_en;
  logic              code_en;
  logic              fb_sync;
  logic              ack_ok;
  logic              ack_bad;
  logic              fb_fault;
  logic              wr_go;
  logic              err_clr;
  logic [3:0]        events;
  logic [31:0]       wr_val;
  logic [31:0]       rd_word;
  logic [31:0]       status_word;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // merge written bytes into an old value by strobe
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  // true for any implemented offset
  function automatic logic is_mapped(input logic [7:0] addr);
    return addr == `SFRC_ADDR_CTRL   || addr == `SFRC_ADDR_STATUS ||
           addr == `SFRC_ADDR_INT_ST || addr == `SFRC_ADDR_INT_MSK ||
           addr == `SFRC_ADDR_FB_WIN;
  endfunction : is_mapped

  // ****************************************************************
  // pin conditioning
  // ****************************************************************
  sfrc_in_cond #(
    .ACK_MIN_CYC (ACK_MIN_CYC),
    .ACK_MAX_CYC (ACK_MAX_CYC)
  ) u_in_cond (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .restart_pin   (restart_pin),
    .feedback_pin  (feedback_pin),
    .feedback_sync (fb_sync),
    .ack_ok        (ack_ok),
    .ack_bad       (ack_bad)
  );

  assign lock_en = ctrl_ff[`SFRC_CTRL_LOCK_EN];
  assign fb_en   = ctrl_ff[`SFRC_CTRL_FB_EN];
  assign code_en = ctrl_ff[`SFRC_CTRL_CODE_EN];

  // ****************************************************************
  // beam evaluation
  // ****************************************************************
  // a foreign-coded beam counts as dark when coding is on
  for (genvar gi = 0; gi < NBEAMS; gi++) begin : g_beam
    assign beam_ok[gi] = beam_seen[gi] &
                         (~code_en | beam_coded[gi]); // [RQ10]
  end

  assign scan_sync  = beam_ok[0] | beam_ok[NBEAMS-1]; // [RQ11]
  assign scan_clear = &beam_ok;
  // act on this scan at once, not one cycle later
  assign field_now  = scan_strobe ? scan_clear : field_clear_ff;

  // field and sync memory, reset as interrupted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      field_clear_ff <= 1'b0;
      sync_lock_ff   <= 1'b0;
    end else if (scan_strobe) begin
      field_clear_ff <= scan_clear;
      sync_lock_ff   <= scan_sync; // [RQ11]
    end
  end

  // ****************************************************************
  // output control
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RUN: begin
        if (fb_fault) begin
          nxt_state = ST_FAULT; // [RQ9]
        end else if (!field_now && lock_en) begin
          nxt_state = ST_LOCKED; // [RQ4]
        end
      end
      ST_LOCKED: begin
        if (fb_fault) begin
          nxt_state = ST_FAULT; // [RQ9]
        end else if (!lock_en) begin
          nxt_state = ST_RUN; // [RQ3]
        end else if (ack_ok && field_now) begin
          nxt_state = ST_RUN; // [RQ6]
        end
      end
      ST_FAULT: begin
        if (err_clr) begin
          nxt_state = ST_LOCKED;
        end
      end
    endcase
  end

  // outputs follow the field only while running
  assign nxt_out = (nxt_state == ST_RUN) && field_now; // [RQ1] [RQ2]

  // start locked so nothing runs before an acknowledgment
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_LOCKED; // [RQ5]
      out_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      out_ff   <= nxt_out;
    end
  end

  assign safety_switching_output = out_ff;
  assign fault_out               = (state_ff == ST_FAULT); // [RQ9]

  // ****************************************************************
  // contactor feedback check
  // ****************************************************************
  // nc contacts: feedback high while the output is off
  assign fb_fault = fb_busy_ff && fb_en && fb_sync != fb_expect_ff &&
                    fb_cnt_ff >= fb_win_ff; // [RQ9]

  // a new switch restarts the window, even mid-check
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fb_busy_ff   <= 1'b0;
      fb_expect_ff <= 1'b1;
      fb_cnt_ff    <= 32'h0000_0000;
    end else if (nxt_out != out_ff && nxt_state != ST_FAULT) begin
      fb_busy_ff   <= 1'b1; // [RQ8]
      fb_expect_ff <= ~nxt_out;
      fb_cnt_ff    <= 32'h0000_0000;
    end else if (fb_busy_ff) begin
      if (fb_sync == fb_expect_ff || fb_fault || !fb_en) begin
        fb_busy_ff <= 1'b0;
      end else begin
        fb_cnt_ff <= fb_cnt_ff + 32'h0000_0001; // [RQ13]
      end
    end
  end

  // ****************************************************************
  // axi4-lite write channel
  // ****************************************************************
  assign awready = ~aw_held_ff & ~bvalid_ff;
  assign wready  = ~w_held_ff & ~bvalid_ff;
  assign wr_go   = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign err_clr = wr_go && awaddr_ff == `SFRC_ADDR_CTRL &&
                   wstrb_ff[1] && wdata_ff[`SFRC_CTRL_ERR_CLR];
  assign wr_val  = wdata_ff & {28'h000_0000, wstrb_ff[0], wstrb_ff[0],
                               wstrb_ff[0], wstrb_ff[0]};

  // address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end else if (wr_go) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= wdata;
        wstrb_ff  <= wstrb;
      end
    end
  end

  // response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `SFRC_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= is_mapped(awaddr_ff) ? `SFRC_RESP_OKAY
                                        : `SFRC_RESP_SLVERR;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign bvalid = bvalid_ff;
  assign bresp  = bresp_ff;

  // ****************************************************************
  // registers
  // ****************************************************************
  // configuration; status is read only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff    <= `SFRC_CTRL_RST;
      int_msk_ff <= `SFRC_INT_RST;
      fb_win_ff  <= 32'(FB_WIN_CYC);
    end else if (wr_go) begin
      if (awaddr_ff == `SFRC_ADDR_CTRL) begin
        ctrl_ff <= 3'(merge({29'h0, ctrl_ff}, wdata_ff, wstrb_ff));
      end
      if (awaddr_ff == `SFRC_ADDR_INT_MSK) begin
        int_msk_ff <= 4'(merge({28'h0, int_msk_ff}, wdata_ff, wstrb_ff));
      end
      if (awaddr_ff == `SFRC_ADDR_FB_WIN) begin
        fb_win_ff <= merge(fb_win_ff, wdata_ff, wstrb_ff);
      end
    end
  end

  assign events[`SFRC_INT_BREAK]    = scan_strobe & field_clear_ff &
                                      ~scan_clear;
  assign events[`SFRC_INT_ACK_OK]   = ack_ok;
  assign events[`SFRC_INT_ACK_BAD]  = ack_bad; // [RQ7]
  assign events[`SFRC_INT_FB_FAULT] = fb_fault;

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_st_ff <= `SFRC_INT_RST;
      irq_ff    <= 1'b0;
    end else begin
      if (wr_go && awaddr_ff == `SFRC_ADDR_INT_ST) begin
        int_st_ff <= (int_st_ff & ~wr_val[3:0]) | events;
      end else begin
        int_st_ff <= int_st_ff | events;
      end
      irq_ff <= |(int_st_ff & int_msk_ff);
    end
  end

  assign irq = irq_ff;

  // ****************************************************************
  // axi4-lite read channel
  // ****************************************************************
  assign status_word = {26'h000_0000, fb_sync, sync_lock_ff,
                        field_clear_ff, fault_out,
                        state_ff == ST_LOCKED, out_ff};

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (araddr)
      `SFRC_ADDR_CTRL:    rd_word = {29'h0, ctrl_ff};
      `SFRC_ADDR_STATUS:  rd_word = status_word;
      `SFRC_ADDR_INT_ST:  rd_word = {28'h0, int_st_ff};
      `SFRC_ADDR_INT_MSK: rd_word = {28'h0, int_msk_ff};
      `SFRC_ADDR_FB_WIN:  rd_word = fb_win_ff;
      default:            rd_word = 32'h0000_0000;
    endcase
  end

  assign arready = ~rvalid_ff;

  // data registered, valid the cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `SFRC_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_word;
      rresp_ff  <= is_mapped(araddr) ? `SFRC_RESP_OKAY
                                     : `SFRC_RESP_SLVERR;
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign rvalid = rvalid_ff;
  assign rdata  = rdata_ff;
  assign rresp  = rresp_ff;

endmodule : sfrc_core

// >>> hw/sfrc_in_cond.sv
// pin conditioning: restart and feedback synchronisers, ack pulse timer
// assumes: restart_pin and feedback_pin are asynchronous pins
`timescale 1ns/1ns
`include "sfrc_consts.svh"

module sfrc_in_cond import sfrc_pkg::*; #(
  parameter int unsigned ACK_MIN_CYC = `SFRC_ACK_MIN_MS * `SFRC_CLK_KHZ,
  parameter int unsigned ACK_MAX_CYC = `SFRC_ACK_MAX_MS * `SFRC_CLK_KHZ
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // pins
  input  wire logic restart_pin,
  input  wire logic feedback_pin,
  // conditioned results
  output logic      feedback_sync,
  output logic      ack_ok,
  output logic      ack_bad
);

  localparam logic [31:0] CNT_SAT = 32'(ACK_MAX_CYC + 1);

  logic [1:0]  meta_ff;
  logic [1:0]  sync_ff;
  logic        rs_prev_ff;
  logic [31:0] hi_cnt_ff;
  logic        ack_ok_ff;
  logic        ack_bad_ff;
  logic        rise;
  logic        fall;
  logic        width_ok;

  // ****************************************************************
  // synchronisers
  // ****************************************************************
  // two stages, first stage read only by the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= 2'h0;
      sync_ff <= 2'h0;
    end else begin
      meta_ff <= {restart_pin, feedback_pin}; // [RQ13]
      sync_ff <= meta_ff;
    end
  end

  assign feedback_sync = sync_ff[0];

  // ****************************************************************
  // acknowledgment pulse timer
  // ****************************************************************
  assign rise     = sync_ff[1] & ~rs_prev_ff;
  assign fall     = ~sync_ff[1] & rs_prev_ff;
  assign width_ok = (hi_cnt_ff >= 32'(ACK_MIN_CYC)) &&
                    (hi_cnt_ff <= 32'(ACK_MAX_CYC)); // [RQ7]

  // high time counter, saturates just past the limit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rs_prev_ff <= 1'b0;
      hi_cnt_ff  <= 32'h0000_0000;
    end else begin
      rs_prev_ff <= sync_ff[1];
      if (rise) begin
        hi_cnt_ff <= 32'h0000_0001;
      end else if (sync_ff[1] && hi_cnt_ff != CNT_SAT) begin
        hi_cnt_ff <= hi_cnt_ff + 32'h0000_0001; // [RQ13]
      end
    end
  end

  // verdict only on the falling edge: low-high-low complete
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_ok_ff  <= 1'b0;
      ack_bad_ff <= 1'b0;
    end else begin
      ack_ok_ff  <= fall & width_ok;  // [RQ7]
      ack_bad_ff <= fall & ~width_ok; // [RQ7]
    end
  end

  assign ack_ok  = ack_ok_ff;
  assign ack_bad = ack_bad_ff;

endmodule : sfrc_in_cond

// >>> hw/sfrc_pkg.sv
// types of the safety output and restart control block
// assumes: compiled before every module of the block
package sfrc_pkg;
  // output control state
  typedef enum logic [1:0] {
    ST_RUN,
    ST_LOCKED,
    ST_FAULT
  } sfrc_state_t;
endpackage : sfrc_pkg
